/* File: core/fpec_pkg.sv */
/*
 * fpec_pkg: register map, field positions, reset values and pulse timing
 * for the flash program/erase sequencer.
 * assumes: a 40 MHz core clock and a byte-addressed register port.
 */
package fpec_pkg;

	// ==========================================================
	// register offsets
	localparam logic [11:0] OFF_TARGET_ADDRESS = 12'h000;
	localparam logic [11:0] OFF_WRITE_DATA = 12'h004;
	localparam logic [11:0] OFF_OPERATION_COMMAND = 12'h008;
	localparam logic [11:0] OFF_INT_STATUS = 12'h00c;
	localparam logic [11:0] OFF_INT_MASK = 12'h010;
	localparam logic [11:0] OFF_INT_MASKED = 12'h014;
	localparam logic [11:0] OFF_READ_PROTECT = 12'h130;
	localparam logic [11:0] OFF_PROGRAM_PROTECT = 12'h134;
	localparam logic [11:0] OFF_TICK_RELOAD = 12'h140;

	// ==========================================================
	// fields
	localparam int ADDR_WIDTH = 14;
	localparam int BLOCK_LSB = 11;
	localparam int BLOCK_COUNT = 8;
	localparam logic [15:0] COMMAND_KEY = 16'ha442;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_PAGE_ERASE_BIT = 1;
	localparam int CMD_FULL_ERASE_BIT = 2;
	localparam int COMMIT_BIT = 3;
	localparam int INT_ACCESS_BIT = 0;
	localparam int INT_DONE_BIT = 1;

	// ==========================================================
	// reset values
	localparam logic [7:0] PROTECT_RESET = 8'hff;
	localparam logic [7:0] TICK_RELOAD_RESET = 8'h18;

	// ==========================================================
	// pulse lengths, in microsecond ticks
	localparam int CLK_MHZ = 40;
	localparam int WRITE_PULSE_US = 50;
	localparam int COMMIT_PULSE_US = 50;
	localparam int PAGE_ERASE_US = 25000;
	localparam int FULL_ERASE_US = 250000;
	localparam int US_COUNT_WIDTH = 18;

	typedef enum logic [1:0] {
		OP_WRITE,
		OP_PAGE_ERASE,
		OP_FULL_ERASE,
		OP_COMMIT
	} fpec_op_type;

endpackage

/* File: core/fpec_tick.sv */
/*
 * fpec_tick: microsecond tick divider, reloaded from a software value.
 * assumes: reload equals the clock rate in MHz minus one.
 */
`timescale 1ns/1ps
`default_nettype none

module fpec_tick (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] reload,
	output logic tick
);

	logic [7:0] count;
	logic [7:0] next_count;
	logic next_tick;

	// ==========================================================
	// divider: one tick every reload+1 clocks
	always_comb begin
		next_tick = (count == 8'h00); // RQ3
		next_count = (count == 8'h00) ? reload : count - 8'h01;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count <= fpec_pkg::TICK_RELOAD_RESET;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	tick_spacing_a: assert property (tick && $past(reload) != 8'h00 |=> !tick) // RQ3
		else $error("tick repeated on consecutive clocks");

endmodule

`default_nettype wire

/* File: core/fpec_core.sv */
/*
 * fpec_core: keyed program/erase sequencer with protection enables,
 * microsecond pulse timing and a done/violation interrupt.
 * assumes: single-cycle register strobes, array consumes level pulses,
 * committed protection values are presented on nv_* after power-on.
 */
// Behaviour
// [RQ1] eight block enables, reset to one, each gating alteration of its 2 KB block
// [RQ2] enable bits clear from one to zero only; reset restores uncommitted values (code reloads the committed nv_* values after reset)
// [RQ3] 8-bit tick reload, reset 0x18, divides clock into microsecond ticks
// [RQ4] software keeps tick reload at clock MHz minus one
// [RQ5] target address holds 14 writable bits; upper bits read zero
// [RQ6] software aligns word writes to 4 bytes, page erases to 1 KB
// [RQ7] write data register holds the word to program; unused by erases
// [RQ8] valid command starts its operation at the target address
// [RQ9] command acts only with key 0xa442 in upper half; key reads zero
// [RQ10] software sets only one operation bit per command
// [RQ11] bit 3 commits a protection register; reads one while pending
// [RQ12] bit 2 erases the whole array; reads one until done
// [RQ13] bit 1 erases the addressed page; reads one until done
// [RQ14] bit 0 programs the data word; reads one until done
// [RQ15] software never modifies reserved bits
// [RQ16] address bit 0 selects program-protect (1) or read-protect (0) for commit
// [RQ17] software polls the busy bit before the next operation
// [RQ18] every finished write or erase sets the done flag
// [RQ19] operations on protected blocks end at once without a pulse
`timescale 1ns/1ps
`default_nettype none

module fpec_core #(
	parameter int PAGE_ERASE_US = fpec_pkg::PAGE_ERASE_US,
	parameter int FULL_ERASE_US = fpec_pkg::FULL_ERASE_US
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic [7:0] nv_program_protect,
	input wire logic [7:0] nv_read_protect,
	output logic [13:0] array_addr,
	output logic [31:0] array_data,
	output logic array_write,
	output logic array_page_erase,
	output logic array_full_erase,
	output logic array_commit,
	output logic array_commit_sel,
	output logic [7:0] array_commit_data,
	output logic irq
);

	typedef enum {ST_IDLE, ST_PULSE} fpec_state_type;

	function automatic logic [2:0] block_of(input logic [13:0] addr);
		block_of = addr[fpec_pkg::BLOCK_LSB +: 3];
	endfunction

	function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
		hit = (addr == off);
	endfunction

	logic [13:0] target_address;
	logic [31:0] write_data;
	logic [7:0] program_protect_enables;
	logic [7:0] read_protect_enables;
	logic [7:0] microsecond_tick_reload;
	logic [1:0] int_status;
	logic [1:0] int_mask;
	logic [3:0] busy;
	logic loading;
	fpec_state_type state;
	logic [fpec_pkg::US_COUNT_WIDTH-1:0] us_left;
	logic tick;

	logic [13:0] next_target_address;
	logic [31:0] next_write_data;
	logic [7:0] next_program_protect_enables;
	logic [7:0] next_read_protect_enables;
	logic [7:0] next_microsecond_tick_reload;
	logic [1:0] next_int_status;
	logic [1:0] next_int_mask;
	logic [3:0] next_busy;
	logic next_loading;
	fpec_state_type next_state;
	logic [fpec_pkg::US_COUNT_WIDTH-1:0] next_us_left;
	logic [31:0] next_reg_rdata;
	logic [13:0] next_array_addr;
	logic [31:0] next_array_data;
	logic next_array_write;
	logic next_array_page_erase;
	logic next_array_full_erase;
	logic next_array_commit;
	logic next_array_commit_sel;
	logic [7:0] next_array_commit_data;
	logic next_irq;

	logic cmd_valid;
	logic allowed;
	logic finish;
	logic [3:0] cmd_bits;

	fpec_tick u_tick (
		.sys_clk(sys_clk),
		.reset(reset),
		.reload(microsecond_tick_reload),
		.tick(tick)
	);

	// ==========================================================
	// command decode
	always_comb begin
		cmd_bits = reg_wdata[3:0];
		cmd_valid = reg_write && hit(reg_addr, fpec_pkg::OFF_OPERATION_COMMAND)
			&& reg_wdata[31:16] == fpec_pkg::COMMAND_KEY
			&& state == ST_IDLE && cmd_bits != 4'h0; // RQ9
		// full erase needs every block open, so a partly locked part keeps its code
		if (cmd_bits[fpec_pkg::CMD_FULL_ERASE_BIT])
			allowed = &program_protect_enables; // RQ19
		else if (cmd_bits[fpec_pkg::COMMIT_BIT])
			allowed = 1'b1;
		else
			allowed = program_protect_enables[block_of(target_address)]; // RQ1
		finish = state == ST_PULSE && tick && us_left <= 18'h00001;
	end

	// ==========================================================
	// registers, sequencer and outputs
	always_comb begin
		next_target_address = target_address;
		next_write_data = write_data;
		next_program_protect_enables = program_protect_enables;
		next_read_protect_enables = read_protect_enables;
		next_microsecond_tick_reload = microsecond_tick_reload;
		next_int_mask = int_mask;
		next_int_status = int_status;
		next_busy = busy;
		next_loading = 1'b0;
		next_state = state;
		next_us_left = us_left;
		next_array_addr = array_addr;
		next_array_data = array_data;
		next_array_write = array_write;
		next_array_page_erase = array_page_erase;
		next_array_full_erase = array_full_erase;
		next_array_commit = array_commit;
		next_array_commit_sel = array_commit_sel;
		next_array_commit_data = array_commit_data;
		next_reg_rdata = 32'h00000000;

		// committed values load on the first clock after every reset, never under the async reset
		if (loading) begin
			next_program_protect_enables = nv_program_protect; // RQ2
			next_read_protect_enables = nv_read_protect;
		end

		if (reg_write) begin
			if (hit(reg_addr, fpec_pkg::OFF_TARGET_ADDRESS))
				next_target_address = reg_wdata[13:0]; // RQ5
			if (hit(reg_addr, fpec_pkg::OFF_WRITE_DATA))
				next_write_data = reg_wdata; // RQ7
			if (hit(reg_addr, fpec_pkg::OFF_TICK_RELOAD))
				next_microsecond_tick_reload = reg_wdata[7:0]; // RQ3
			if (hit(reg_addr, fpec_pkg::OFF_INT_MASK))
				next_int_mask = reg_wdata[1:0];
			if (hit(reg_addr, fpec_pkg::OFF_INT_STATUS))
				next_int_status = int_status & ~reg_wdata[1:0];
			if (hit(reg_addr, fpec_pkg::OFF_PROGRAM_PROTECT) && !loading)
				next_program_protect_enables = program_protect_enables & reg_wdata[7:0]; // RQ2
			if (hit(reg_addr, fpec_pkg::OFF_READ_PROTECT) && !loading)
				next_read_protect_enables = read_protect_enables & reg_wdata[7:0]; // RQ2
		end

		case (state)
			ST_IDLE: begin
				if (cmd_valid) begin
					next_busy = cmd_bits; // RQ8
					next_array_addr = target_address;
					next_array_data = write_data; // RQ14
					if (!allowed) begin
						// rejected: busy stays zero, no pulse reaches the array
						next_busy = 4'h0; // RQ19
						next_int_status[fpec_pkg::INT_ACCESS_BIT] = 1'b1;
						next_int_status[fpec_pkg::INT_DONE_BIT] = 1'b1; // RQ18
					end else begin
						next_state = ST_PULSE;
						if (cmd_bits[fpec_pkg::COMMIT_BIT]) begin
							next_array_commit = 1'b1; // RQ11
							next_array_commit_sel = target_address[0]; // RQ16
							next_array_commit_data = target_address[0] ?
								program_protect_enables : read_protect_enables;
							next_us_left = 18'(fpec_pkg::COMMIT_PULSE_US);
						end else if (cmd_bits[fpec_pkg::CMD_FULL_ERASE_BIT]) begin
							next_array_full_erase = 1'b1; // RQ12
							next_us_left = 18'(FULL_ERASE_US);
						end else if (cmd_bits[fpec_pkg::CMD_PAGE_ERASE_BIT]) begin
							next_array_page_erase = 1'b1; // RQ13
							next_us_left = 18'(PAGE_ERASE_US);
						end else begin
							next_array_write = 1'b1; // RQ14
							next_us_left = 18'(fpec_pkg::WRITE_PULSE_US);
						end
					end
				end
			end
			ST_PULSE: begin
				if (tick)
					next_us_left = us_left - 18'h00001;
				if (finish) begin
					next_state = ST_IDLE;
					next_busy = 4'h0;
					next_array_write = 1'b0;
					next_array_page_erase = 1'b0;
					next_array_full_erase = 1'b0;
					next_array_commit = 1'b0;
					if (!busy[fpec_pkg::COMMIT_BIT])
						next_int_status[fpec_pkg::INT_DONE_BIT] = 1'b1; // RQ18
				end
			end
			default: next_state = ST_IDLE;
		endcase

		// read data one cycle after the strobe; unmapped reads return zero
		if (reg_read) begin
			case (reg_addr)
				fpec_pkg::OFF_TARGET_ADDRESS: next_reg_rdata = {18'h00000, target_address}; // RQ5
				fpec_pkg::OFF_WRITE_DATA: next_reg_rdata = write_data;
				fpec_pkg::OFF_OPERATION_COMMAND: next_reg_rdata = {28'h0000000, busy}; // RQ9
				fpec_pkg::OFF_INT_STATUS: next_reg_rdata = {30'h00000000, int_status};
				fpec_pkg::OFF_INT_MASK: next_reg_rdata = {30'h00000000, int_mask};
				fpec_pkg::OFF_INT_MASKED: next_reg_rdata = {30'h00000000, int_status & int_mask};
				fpec_pkg::OFF_READ_PROTECT: next_reg_rdata = {24'h000000, read_protect_enables};
				fpec_pkg::OFF_PROGRAM_PROTECT: next_reg_rdata = {24'h000000, program_protect_enables};
				fpec_pkg::OFF_TICK_RELOAD: next_reg_rdata = {24'h000000, microsecond_tick_reload};
				default: next_reg_rdata = 32'h00000000;
			endcase
		end
		next_irq = |(next_int_status & next_int_mask);
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			target_address <= 14'h0000;
			write_data <= 32'h00000000;
			program_protect_enables <= fpec_pkg::PROTECT_RESET; // RQ1
			read_protect_enables <= fpec_pkg::PROTECT_RESET;
			microsecond_tick_reload <= fpec_pkg::TICK_RELOAD_RESET; // RQ3
			int_status <= 2'h0;
			int_mask <= 2'h0;
			busy <= 4'h0;
			loading <= 1'b1;
			state <= ST_IDLE;
			us_left <= 18'h00000;
			reg_rdata <= 32'h00000000;
			array_addr <= 14'h0000;
			array_data <= 32'h00000000;
			array_write <= 1'b0;
			array_page_erase <= 1'b0;
			array_full_erase <= 1'b0;
			array_commit <= 1'b0;
			array_commit_sel <= 1'b0;
			array_commit_data <= 8'h00;
			irq <= 1'b0;
		end else begin
			target_address <= next_target_address;
			write_data <= next_write_data;
			program_protect_enables <= next_program_protect_enables;
			read_protect_enables <= next_read_protect_enables;
			microsecond_tick_reload <= next_microsecond_tick_reload;
			int_status <= next_int_status;
			int_mask <= next_int_mask;
			busy <= next_busy;
			loading <= next_loading;
			state <= next_state;
			us_left <= next_us_left;
			reg_rdata <= next_reg_rdata;
			array_addr <= next_array_addr;
			array_data <= next_array_data;
			array_write <= next_array_write;
			array_page_erase <= next_array_page_erase;
			array_full_erase <= next_array_full_erase;
			array_commit <= next_array_commit;
			array_commit_sel <= next_array_commit_sel;
			array_commit_data <= next_array_commit_data;
			irq <= next_irq;
		end
	end

	// ==========================================================
	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_valid_write;
		reg_write && hit(reg_addr, fpec_pkg::OFF_OPERATION_COMMAND) && state == ST_IDLE;
	endsequence

	sequence s_open_word_write;
		s_valid_write ##0 reg_wdata == 32'ha4420001 && allowed;
	endsequence

	bad_key_ignored_a: assert property (s_valid_write ##0 reg_wdata[31:16] != 16'ha442
		|=> busy == 4'h0 && state == ST_IDLE) // RQ9
		else $error("command without key took effect");
	word_write_start_a: assert property (s_open_word_write
		|=> busy[0] && array_write && array_data == $past(write_data)) // RQ14
		else $error("word write did not start");
	write_pulse_held_a: assert property ($rose(array_write) |-> array_write[*8]) // RQ14
		else $error("write pulse too short");
	protect_no_set_a: assert property (!$past(loading)
		|-> (program_protect_enables & ~$past(program_protect_enables)) == 8'h00) // RQ2
		else $error("protect enable rose without reset");
	reject_locked_a: assert property (s_valid_write ##0 reg_wdata[31:16] == 16'ha442
		&& reg_wdata[3:0] != 4'h0 && !allowed
		|=> busy == 4'h0 && !array_write && !array_page_erase && !array_full_erase) // RQ19
		else $error("protected block was altered");
	done_flag_a: assert property ($fell(|busy) && !$past(busy[3]) |-> int_status[1]) // RQ18
		else $error("done flag not set on completion");
	commit_select_a: assert property ($rose(array_commit)
		|-> array_commit_sel == $past(target_address[0]) && busy[3]) // RQ16
		else $error("commit selected wrong register");

	key_reads_zero_a: assert property (reg_read && reg_addr == 12'h008
		|=> reg_rdata[31:4] == 28'h0000000) // RQ9
		else $error("key field read back nonzero");

	addr_upper_zero_a: assert property (reg_read && reg_addr == 12'h000
		|=> reg_rdata[31:14] == 18'h00000) // RQ5
		else $error("address reserved bits nonzero");

	irq_follows_a: assert property (##1 irq == |(int_status & int_mask))
		else $error("interrupt does not match status");

endmodule

`default_nettype wire

/* File: verification/fpec_array_model.sv */
/*
 * fpec_array_model: stand-in for the flash array, measuring each pulse
 * and keeping the committed protection values across resets.
 * assumes: pulses are level signals registered on the rising sys_clk edge.
 */
`timescale 1ns/1ps
`default_nettype none

module fpec_array_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic array_write,
	input wire logic array_page_erase,
	input wire logic array_full_erase,
	input wire logic array_commit,
	input wire logic array_commit_sel,
	input wire logic [7:0] array_commit_data,
	output logic [31:0] pulse_len,
	output logic [7:0] pulse_count,
	output logic [7:0] nv_program_protect,
	output logic [7:0] nv_read_protect
);
	// ==========================================================
	// pulse measurement
	// the array only listens; a pulse is timed from rise to fall in clocks
	logic active;
	logic was;
	logic [31:0] run;
	assign active = array_write | array_page_erase | array_full_erase | array_commit;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			was <= 1'b0;
			run <= 32'h0;
			pulse_len <= 32'h0;
			pulse_count <= 8'h0;
		end else begin
			was <= active;
			run <= active ? run + 32'h1 : 32'h0;
			if (was && !active) begin
				pulse_len <= run;
				pulse_count <= pulse_count + 8'h1;
			end
		end
	end

	// ==========================================================
	// protection store
	// nonvolatile: factory value at power-up, untouched by reset, replaced by a commit
	logic [7:0] nv_pp = 8'hff;
	logic [7:0] nv_rp = 8'hff;
	assign nv_program_protect = nv_pp;
	assign nv_read_protect = nv_rp;
	always @(posedge sys_clk) begin
		if (array_commit && array_commit_sel)
			nv_pp <= array_commit_data;
		if (array_commit && !array_commit_sel)
			nv_rp <= array_commit_data;
	end
endmodule

`default_nettype wire

/* File: verification/tb_fpec_core.sv */
/*
 * tb_fpec_core: register-level tests of the program/erase sequencer.
 * assumes: erase lengths shortened by parameter; the array model keeps the nv store.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_fpec_core;
	// ==========================================================
	// signals
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [11:0] reg_addr = 12'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic [13:0] array_addr;
	logic [31:0] array_data;
	logic array_write, array_page_erase, array_full_erase, array_commit;
	logic array_commit_sel;
	logic [7:0] array_commit_data;
	logic irq;
	logic [31:0] pulse_len;
	logic [7:0] pulse_count;
	logic [7:0] nv_pp;
	logic [7:0] nv_rp;
	logic [31:0] v;
	logic [7:0] npc;
	logic [13:0] s_addr;
	logic [31:0] s_data;
	logic s_sel;
	logic [7:0] s_cdata;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;

	always #12.5 sys_clk = ~sys_clk;

	fpec_core #(.PAGE_ERASE_US(20), .FULL_ERASE_US(30)) fpec_core_inst (
		.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.nv_program_protect(nv_pp), .nv_read_protect(nv_rp),
		.array_addr(array_addr), .array_data(array_data), .array_write(array_write),
		.array_page_erase(array_page_erase), .array_full_erase(array_full_erase),
		.array_commit(array_commit), .array_commit_sel(array_commit_sel),
		.array_commit_data(array_commit_data), .irq(irq));

	fpec_array_model fpec_array_model_inst (
		.sys_clk(sys_clk), .reset(reset), .array_write(array_write),
		.array_page_erase(array_page_erase), .array_full_erase(array_full_erase),
		.array_commit(array_commit), .array_commit_sel(array_commit_sel),
		.array_commit_data(array_commit_data), .pulse_len(pulse_len),
		.pulse_count(pulse_count), .nv_program_protect(nv_pp), .nv_read_protect(nv_rp));

	// ==========================================================
	// tasks
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// strobes rise after one edge and drop after the next, so calls never collide
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// issue a command, snapshot the array side, poll busy, time the pulse
	task automatic op(input logic [31:0] cmd, input logic [31:0] busy, input int n, input int r);
		int k;
		logic ok;
		wr(12'h008, cmd);
		#1;
		s_addr = array_addr;
		s_data = array_data;
		s_sel = array_commit_sel;
		s_cdata = array_commit_data;
		rd(12'h008, v);
		check(v, busy);
		k = 0;
		while (v !== 32'h0 && k < 20000) begin
			rd(12'h008, v);
			k++;
		end
		check(v, 32'h0);
		ok = (pulse_len >= (n - 1) * (r + 1)) && (pulse_len <= n * (r + 1) + 1);
		check({31'h0, ok}, 32'h1);
	endtask

	task automatic do_reset();
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask

	// ==========================================================
	// watchdog: the longest op is about 2000 clocks
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles >= 20000) begin
			failures++;
			conclude();
		end
	end

	// ==========================================================
	// tests
	initial begin
		do_reset();
		rd(12'h140, v); check(v, 32'h18);
		rd(12'h134, v); check(v, 32'hff);
		rd(12'h008, v); check(v, 32'h0);
		wr(12'h000, 32'h00003fff);
		rd(12'h000, v); check(v, 32'h3fff);
		rd(12'h020, v); check(v, 32'h0);
		wr(12'h004, 32'h12345678);
		rd(12'h004, v); check(v, 32'h12345678);
		wr(12'h000, 32'h0104);
		wr(12'h010, 32'h2);
		// reload kept at clock MHz minus one for every real pulse
		wr(12'h140, 32'h27);
		op(32'ha4420001, 32'h1, 50, 39);
		check({18'h0, s_addr}, 32'h0104);
		check(s_data, 32'h12345678);
		rd(12'h00c, v); check(v, 32'h2);
		check({31'h0, irq}, 32'h1);
		wr(12'h00c, 32'h2);
		rd(12'h00c, v); check(v, 32'h0);
		check({31'h0, irq}, 32'h0);
		// wrong key must leave everything idle
		npc = pulse_count;
		wr(12'h008, 32'ha4430001);
		rd(12'h008, v); check(v, 32'h0);
		check({24'h0, pulse_count}, {24'h0, npc});
		wr(12'h140, 32'h0);
		rd(12'h140, v); check(v, 32'h0);
		wr(12'h140, 32'h27);
		wr(12'h000, 32'h0400);
		op(32'ha4420002, 32'h2, 20, 39);
		check({18'h0, s_addr}, 32'h0400);
		op(32'ha4420004, 32'h4, 30, 39);
		rd(12'h00c, v); check(v, 32'h2);
		wr(12'h00c, 32'h2);
		// enables clear only; a cleared bit cannot be set again
		wr(12'h134, 32'h7f);
		wr(12'h134, 32'hff);
		rd(12'h134, v); check(v, 32'h7f);
		wr(12'h000, 32'h0001);
		op(32'ha4420008, 32'h8, 50, 39);
		check({31'h0, s_sel}, 32'h1);
		check({24'h0, s_cdata}, 32'h7f);
		rd(12'h00c, v); check(v, 32'h0);
		// block 7 is now locked: write and mass erase end without a pulse
		npc = pulse_count;
		wr(12'h000, 32'h3800);
		wr(12'h008, 32'ha4420001);
		rd(12'h008, v); check(v, 32'h0);
		rd(12'h00c, v); check(v, 32'h3);
		wr(12'h00c, 32'h3);
		wr(12'h008, 32'ha4420004);
		rd(12'h008, v); check(v, 32'h0);
		check({24'h0, pulse_count}, {24'h0, npc});
		// an uncommitted clear is lost at reset, the committed 0x7f survives
		wr(12'h134, 32'h3f);
		rd(12'h134, v); check(v, 32'h3f);
		do_reset();
		rd(12'h134, v); check(v, 32'h7f);
		rd(12'h130, v); check(v, 32'hff);
		rd(12'h140, v); check(v, 32'h18);
		conclude();
	end
endmodule

`default_nettype wire
